// ### pp_pkg.sv
package pp_pkg;

  // ----------------------------------------------------------------
  // load strobe action codes
  // ----------------------------------------------------------------
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;

  // ----------------------------------------------------------------
  // command bytes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_NOP        = 8'h00;
  localparam logic [7:0] CMD_FUSE_WRITE = 8'h40;
  localparam logic [7:0] CMD_LOCK_WRITE = 8'h20;
  localparam logic [7:0] CMD_FLASH_WR   = 8'h10;
  localparam logic [7:0] CMD_EE_WR      = 8'h11;
  localparam logic [7:0] CMD_SIG_READ   = 8'h08;
  localparam logic [7:0] CMD_FUSE_READ  = 8'h04;
  localparam logic [7:0] CMD_FLASH_RD   = 8'h02;
  localparam logic [7:0] CMD_EE_RD      = 8'h03;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int FLASH_WORDS      = 16384;
  localparam int FLASH_PAGE_WORDS = 64;
  localparam int EE_BYTES         = 1024;
  localparam int EE_PAGE_BYTES    = 4;

  // ----------------------------------------------------------------
  // reset values of nonvolatile cells (erased = all ones)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ERASED_BYTE  = 8'hff;
  localparam logic [15:0] ERASED_WORD  = 16'hffff;
  localparam logic [7:0]  FUSE_LO_RST  = 8'hff;
  localparam logic [7:0]  FUSE_HI_RST  = 8'hff;
  localparam logic [7:0]  FUSE_EXT_RST = 8'hff;
  localparam logic [7:0]  LOCK_RST     = 8'hff;
  // identification bytes: arbitrary neutral values
  localparam logic [7:0]  SIG_BYTE0    = 8'h5a;
  localparam logic [7:0]  SIG_BYTE1    = 8'h3c;
  localparam logic [7:0]  SIG_BYTE2    = 8'h0f;
  localparam logic [7:0]  CAL_BYTE     = 8'h80;

  // ----------------------------------------------------------------
  // programming times
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 20;
  localparam int FLASH_WRITE_US = 4500;
  localparam int EE_WRITE_US    = 3600;
  localparam int FUSE_WRITE_US  = 4500;
  localparam int TIMER_W        = 17;
  localparam logic [TIMER_W-1:0] FLASH_WRITE_CYCLES = TIMER_W'(FLASH_WRITE_US * CLK_MHZ);
  localparam logic [TIMER_W-1:0] EE_WRITE_CYCLES    = TIMER_W'(EE_WRITE_US * CLK_MHZ);
  localparam logic [TIMER_W-1:0] FUSE_WRITE_CYCLES  = TIMER_W'(FUSE_WRITE_US * CLK_MHZ);

endpackage

// ### prog_timer_if.sv
`timescale 1ns/1ps
interface prog_timer_if;
  logic                       start;
  logic [pp_pkg::TIMER_W-1:0] cycles;
  logic                       busy;

  modport ctrl  (output start, output cycles, input busy);
  modport timer (input start, input cycles, output busy);
endinterface

// ### prog_timer.sv
`timescale 1ns/1ps
module prog_timer (
  // clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        resetn_in,
  // control side
  prog_timer_if.timer      tmr
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } tstate_t;

  typedef struct packed {
    tstate_t                    st;
    logic [pp_pkg::TIMER_W-1:0] cnt;
  } tmr_t;

  tmr_t s_r;
  tmr_t s_nxt;

  // ----------------------------------------------------------------
  // busy countdown
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      ST_IDLE: begin
        if (tmr.start) begin
          s_nxt.st  = ST_BUSY;
          s_nxt.cnt = tmr.cycles - pp_pkg::TIMER_W'(1);
        end
      end
      ST_BUSY: begin
        if (s_r.cnt == '0) begin
          s_nxt.st = ST_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - pp_pkg::TIMER_W'(1);
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
    if (!resetn_in) begin
      s_nxt.st  = ST_IDLE;
      s_nxt.cnt = '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    s_r <= s_nxt;
  end

  // busy straight from the state flop
  assign tmr.busy = (s_r.st == ST_BUSY);

endmodule

// ### parallel_program_port.sv
// Operation
// [RULE_01] Action 10 with byte select low: load strobe rise stores the command.
// [RULE_02] Action 00: load strobe rise stores low or high address byte.
// [RULE_03] Action 01: load strobe rise stores low or high data byte.
// [RULE_04] Command 0x10 is flash page write into the flash page buffer.
// [RULE_05] Page latch rise with byte select high buffers the data word.
// [RULE_06] Low address bits pick the word, upper bits the page.
// [RULE_07] Write pulse programs the buffered page; ready/busy low until done.
// [RULE_08] Programmer waits for ready before further loads or commands.
// [RULE_09] Command 0x00 is no operation and clears the write session.
// [RULE_10] Command 0x11 fills the EEPROM buffer; write with byte select low programs.
// [RULE_11] Command 0x02 with output enable low reads flash low/high byte.
// [RULE_12] Command 0x03 with output enable low reads the EEPROM byte.
// [RULE_13] Command 0x40 writes low data into low, high or extended fuses.
// [RULE_14] Command 0x20 programs lock bits; lock mode 3 freezes boot lock bits.
// [RULE_15] Lock bits never return to unprogrammed through the lock write.
// [RULE_16] Command 0x04 reads fuses or lock bits chosen by the byte selects.
// [RULE_17] Command 0x08 with byte select low reads signature byte 0 to 2.
// [RULE_18] Signature command, address 0, byte select high reads calibration byte.
// [RULE_19] Ready/busy reads 0 while programming and 1 when idle.
// [RULE_20] Data bus driven only while output enable is low; here the drive enable follows output enable one clock late.
// [RULE_21] Command and address persist across operations.
// [RULE_22] Selects and data sampled only at the load strobe rising edge; the byte selects are also sampled at page latch, write pulse and reads.
// [RULE_23] Programmer keeps output enable high while driving the bus.
`timescale 1ns/1ps
module parallel_program_port #(
  parameter int FLASH_WORDS      = pp_pkg::FLASH_WORDS,
  parameter int FLASH_PAGE_WORDS = pp_pkg::FLASH_PAGE_WORDS,
  parameter int EE_BYTES         = pp_pkg::EE_BYTES,
  parameter int EE_PAGE_BYTES    = pp_pkg::EE_PAGE_BYTES,
  parameter logic [pp_pkg::TIMER_W-1:0] FLASH_WRITE_CYCLES = pp_pkg::FLASH_WRITE_CYCLES,
  parameter logic [pp_pkg::TIMER_W-1:0] EE_WRITE_CYCLES    = pp_pkg::EE_WRITE_CYCLES,
  parameter logic [pp_pkg::TIMER_W-1:0] FUSE_WRITE_CYCLES  = pp_pkg::FUSE_WRITE_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       resetn_in,
  // programming strobes and selects
  input  wire logic       load_action_hi_in,
  input  wire logic       load_action_lo_in,
  input  wire logic       load_strobe_in,
  input  wire logic       byte_select_lo_in,
  input  wire logic       byte_select_ext_in,
  input  wire logic       page_latch_strobe_in,
  input  wire logic       write_pulse_n_in,
  input  wire logic       output_enable_n_in,
  // data bus, split
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n_out,
  // status
  output logic            ready_busy_flag_out
);

  localparam int FA_W = $clog2(FLASH_WORDS);
  localparam int PW_W = $clog2(FLASH_PAGE_WORDS);
  localparam int EA_W = $clog2(EE_BYTES);
  localparam int EP_W = $clog2(EE_PAGE_BYTES);

  // ----------------------------------------------------------------
  // block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                               ls_prev;
    logic                               pl_prev;
    logic                               wr_prev;
    logic [7:0]                         cmd;
    logic [7:0]                         addr_lo;
    logic [7:0]                         addr_hi;
    logic [7:0]                         dat_lo;
    logic [7:0]                         dat_hi;
    logic [FLASH_WORDS-1:0][15:0]       flash;
    logic [FLASH_PAGE_WORDS-1:0][15:0]  fbuf;
    logic [EE_BYTES-1:0][7:0]           eeprom;
    logic [EE_PAGE_BYTES-1:0][7:0]      ebuf;
    logic [7:0]                         fuse_lo;
    logic [7:0]                         fuse_hi;
    logic [7:0]                         fuse_ext;
    logic [7:0]                         lock;
    logic [7:0]                         rd_data;
    logic                               drive_n;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  prog_timer_if tmr_if ();

  logic [1:0]      action;
  logic            ls_rise;
  logic            pl_rise;
  logic            wr_fall;
  logic            ready;
  logic [15:0]     full_addr;
  logic [FA_W-1:0] flash_addr;
  logic [EA_W-1:0] ee_addr;

  // ----------------------------------------------------------------
  // strobe edges and address forms
  // ----------------------------------------------------------------
  assign action     = {load_action_hi_in, load_action_lo_in};
  assign ls_rise    = load_strobe_in & ~st_r.ls_prev;                // RULE_22
  assign pl_rise    = page_latch_strobe_in & ~st_r.pl_prev;
  assign wr_fall    = ~write_pulse_n_in & st_r.wr_prev;
  assign ready      = ~tmr_if.busy;
  assign full_addr  = {st_r.addr_hi, st_r.addr_lo};
  assign flash_addr = full_addr[FA_W-1:0];
  assign ee_addr    = full_addr[EA_W-1:0];

  // ----------------------------------------------------------------
  // loads, latches, writes and read path
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ls_prev = load_strobe_in;
    st_nxt.pl_prev = page_latch_strobe_in;
    st_nxt.wr_prev = write_pulse_n_in;
    tmr_if.start   = 1'b0;
    tmr_if.cycles  = FLASH_WRITE_CYCLES;

    // load strobe: command, address or data byte
    if (ls_rise) begin
      case (action)
        pp_pkg::ACT_CMD: begin
          if (!byte_select_lo_in) begin
            st_nxt.cmd = data_in;                                    // RULE_01
            if (data_in == pp_pkg::CMD_NOP) begin
              st_nxt.fbuf = {FLASH_PAGE_WORDS{pp_pkg::ERASED_WORD}}; // RULE_09
              st_nxt.ebuf = {EE_PAGE_BYTES{pp_pkg::ERASED_BYTE}};    // RULE_09
            end
          end
        end
        pp_pkg::ACT_ADDR: begin
          if (byte_select_lo_in) begin
            st_nxt.addr_hi = data_in;                                // RULE_02
          end else begin
            st_nxt.addr_lo = data_in;                                // RULE_02
          end
        end
        pp_pkg::ACT_DATA: begin
          if (byte_select_lo_in) begin
            st_nxt.dat_hi = data_in;                                 // RULE_03
          end else begin
            st_nxt.dat_lo = data_in;                                 // RULE_03
          end
        end
        default: begin
          st_nxt.cmd = st_r.cmd;                                     // RULE_21
        end
      endcase
    end

    // page latch: data into the page buffer at the word position
    if (pl_rise) begin
      if (st_r.cmd == pp_pkg::CMD_FLASH_WR && byte_select_lo_in) begin
        st_nxt.fbuf[st_r.addr_lo[PW_W-1:0]] = {st_r.dat_hi, st_r.dat_lo}; // RULE_05
      end else if (st_r.cmd == pp_pkg::CMD_EE_WR) begin
        st_nxt.ebuf[st_r.addr_lo[EP_W-1:0]] = st_r.dat_lo;           // RULE_10
      end
    end

    // write pulse: refused while a previous operation is still busy
    if (wr_fall && ready) begin
      case (st_r.cmd)
        pp_pkg::CMD_FLASH_WR: begin
          for (int i = 0; i < FLASH_PAGE_WORDS; i++) begin
            st_nxt.flash[{flash_addr[FA_W-1:PW_W], PW_W'(i)}] = st_r.fbuf[i]; // RULE_04 RULE_06
          end
          tmr_if.start  = 1'b1;                                      // RULE_07
          tmr_if.cycles = FLASH_WRITE_CYCLES;
        end
        pp_pkg::CMD_EE_WR: begin
          if (!byte_select_lo_in) begin
            for (int j = 0; j < EE_PAGE_BYTES; j++) begin
              st_nxt.eeprom[{ee_addr[EA_W-1:EP_W], EP_W'(j)}] = st_r.ebuf[j]; // RULE_10
            end
            tmr_if.start  = 1'b1;                                    // RULE_10
            tmr_if.cycles = EE_WRITE_CYCLES;
          end
        end
        pp_pkg::CMD_FUSE_WRITE: begin
          case ({byte_select_ext_in, byte_select_lo_in})
            2'h0: begin
              st_nxt.fuse_lo = st_r.dat_lo;                          // RULE_13
              tmr_if.start   = 1'b1;
            end
            2'h1: begin
              st_nxt.fuse_hi = st_r.dat_lo;                          // RULE_13
              tmr_if.start   = 1'b1;
            end
            2'h2: begin
              st_nxt.fuse_ext = st_r.dat_lo;                         // RULE_13
              tmr_if.start    = 1'b1;
            end
            default: begin
              st_nxt.fuse_lo = st_r.fuse_lo;
            end
          endcase
          tmr_if.cycles = FUSE_WRITE_CYCLES;
        end
        pp_pkg::CMD_LOCK_WRITE: begin
          // only clears bits; boot lock bits frozen in lock mode 3
          st_nxt.lock[1:0] = st_r.lock[1:0] & st_r.dat_lo[1:0];      // RULE_15
          if (st_r.lock[1:0] != 2'h0) begin
            st_nxt.lock[5:2] = st_r.lock[5:2] & st_r.dat_lo[5:2];    // RULE_14
          end
          tmr_if.start  = 1'b1;
          tmr_if.cycles = FUSE_WRITE_CYCLES;
        end
        default: begin
          tmr_if.start = 1'b0;
        end
      endcase
    end

    // read data, registered every cycle
    st_nxt.rd_data = pp_pkg::ERASED_BYTE;
    case (st_r.cmd)
      pp_pkg::CMD_FLASH_RD: begin
        st_nxt.rd_data = byte_select_lo_in ? st_r.flash[flash_addr][15:8]
                                           : st_r.flash[flash_addr][7:0]; // RULE_11
      end
      pp_pkg::CMD_EE_RD: begin
        if (!byte_select_lo_in) begin
          st_nxt.rd_data = st_r.eeprom[ee_addr];                     // RULE_12
        end
      end
      pp_pkg::CMD_FUSE_READ: begin
        case ({byte_select_ext_in, byte_select_lo_in})
          2'h0:    st_nxt.rd_data = st_r.fuse_lo;                    // RULE_16
          2'h3:    st_nxt.rd_data = st_r.fuse_hi;                    // RULE_16
          2'h2:    st_nxt.rd_data = st_r.fuse_ext;                   // RULE_16
          default: st_nxt.rd_data = st_r.lock;                       // RULE_16
        endcase
      end
      pp_pkg::CMD_SIG_READ: begin
        if (byte_select_lo_in) begin
          if (st_r.addr_lo == 8'h00) begin
            st_nxt.rd_data = pp_pkg::CAL_BYTE;                       // RULE_18
          end
        end else begin
          case (st_r.addr_lo)
            8'h00:   st_nxt.rd_data = pp_pkg::SIG_BYTE0;             // RULE_17
            8'h01:   st_nxt.rd_data = pp_pkg::SIG_BYTE1;             // RULE_17
            8'h02:   st_nxt.rd_data = pp_pkg::SIG_BYTE2;             // RULE_17
            default: st_nxt.rd_data = pp_pkg::ERASED_BYTE;
          endcase
        end
      end
      default: begin
        st_nxt.rd_data = pp_pkg::ERASED_BYTE;
      end
    endcase
    st_nxt.drive_n = output_enable_n_in;                             // RULE_20

    // synchronous reset: erased arrays, idle strobes
    if (!resetn_in) begin
      st_nxt          = '1;
      st_nxt.ls_prev  = 1'b0;
      st_nxt.pl_prev  = 1'b0;
      st_nxt.cmd      = pp_pkg::CMD_NOP;
      st_nxt.addr_lo  = 8'h00;
      st_nxt.addr_hi  = 8'h00;
      st_nxt.fuse_lo  = pp_pkg::FUSE_LO_RST;
      st_nxt.fuse_hi  = pp_pkg::FUSE_HI_RST;
      st_nxt.fuse_ext = pp_pkg::FUSE_EXT_RST;
      st_nxt.lock     = pp_pkg::LOCK_RST;
      st_nxt.rd_data  = pp_pkg::ERASED_BYTE;
      tmr_if.start    = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // programming timer
  // ----------------------------------------------------------------
  prog_timer u_timer (
    .ref_clk_in (ref_clk_in),
    .resetn_in  (resetn_in),
    .tmr        (tmr_if.timer)
  );

  // outputs
  assign data_out            = st_r.rd_data;
  assign data_oe_n_out       = st_r.drive_n;                         // RULE_20
  assign ready_busy_flag_out = ready;                                // RULE_19

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);

  // loads land in the right holding byte
  cmd_load_a: assert property (ls_rise && action == pp_pkg::ACT_CMD && !byte_select_lo_in // RULE_01
    |=> st_r.cmd == $past(data_in)) else $error("command byte not stored");
  addr_load_a: assert property (ls_rise && action == pp_pkg::ACT_ADDR // RULE_02
    |=> ($past(byte_select_lo_in) ? st_r.addr_hi : st_r.addr_lo) == $past(data_in))
    else $error("address byte not stored");
  data_hi_a: assert property (ls_rise && action == pp_pkg::ACT_DATA && byte_select_lo_in // RULE_03
    |=> st_r.dat_hi == $past(data_in) && $stable(st_r.dat_lo)) else $error("data high lost");

  // write pulses and the busy timer
  busy_start_a: assert property (wr_fall && ready && st_r.cmd == pp_pkg::CMD_FLASH_WR // RULE_07
    |=> !ready_busy_flag_out [*2]) else $error("busy not shown after write");
  fuse_lo_a: assert property (wr_fall && ready && st_r.cmd == pp_pkg::CMD_FUSE_WRITE // RULE_13
    && !byte_select_ext_in && !byte_select_lo_in |=> st_r.fuse_lo == $past(st_r.dat_lo))
    else $error("low fuse not written");
  ee_refuse_a: assert property (wr_fall && ready && st_r.cmd == pp_pkg::CMD_EE_WR // RULE_10
    && byte_select_lo_in |=> ready_busy_flag_out) else $error("eeprom write not refused");

  // bus drive and no-operation clear
  bus_drive_a: assert property (data_oe_n_out == $past(output_enable_n_in)) // RULE_20
    else $error("bus drive wrong");
  nop_clear_a: assert property (ls_rise && action == pp_pkg::ACT_CMD && !byte_select_lo_in // RULE_09
    && data_in == pp_pkg::CMD_NOP |=> st_r.cmd == pp_pkg::CMD_NOP
    && st_r.fbuf[0] == pp_pkg::ERASED_WORD) else $error("no operation did not clear");

  // lock bits only move toward programmed, then the signature, calibration and eeprom reads
  lock_keep_a: assert property (((st_r.lock & ~$past(st_r.lock)) == 8'h00)) // RULE_15
    else $error("lock bit unprogrammed");
  boot_lock_a: assert property ($past(st_r.lock[1:0]) == 2'h0 // RULE_14
    |-> st_r.lock[5:2] == $past(st_r.lock[5:2])) else $error("boot lock changed in mode 3");
  sig_read_a: assert property (st_r.cmd == pp_pkg::CMD_SIG_READ && !byte_select_lo_in // RULE_17
    && st_r.addr_lo == 8'h01 ##1 $stable(st_r.cmd) && $stable(st_r.addr_lo)
    |-> data_out == pp_pkg::SIG_BYTE1) else $error("signature byte wrong");
  cal_read_a: assert property (st_r.cmd == pp_pkg::CMD_SIG_READ && byte_select_lo_in // RULE_18
    && st_r.addr_lo == 8'h00 |=> data_out == pp_pkg::CAL_BYTE) else $error("calibration wrong");
  ee_read_a: assert property (st_r.cmd == pp_pkg::CMD_EE_RD && byte_select_lo_in // RULE_12
    |=> data_out == pp_pkg::ERASED_BYTE) else $error("eeprom read not refused");

  // main scenarios reached
  flash_prog_c: cover property (wr_fall && ready && st_r.cmd == pp_pkg::CMD_FLASH_WR);
  ee_prog_c:    cover property (wr_fall && ready && st_r.cmd == pp_pkg::CMD_EE_WR);
  fuse_read_c:  cover property (st_r.cmd == pp_pkg::CMD_FUSE_READ && !data_oe_n_out);
  busy_end_c:   cover property (!ready_busy_flag_out ##1 ready_busy_flag_out);
  lock_mode_c:  cover property (st_r.lock[1:0] == 2'h0);

endmodule

// ### programmer_model.sv
`timescale 1ns/1ps
module programmer_model (
  // clock and device status
  input  wire logic       ref_clk_in,
  input  wire logic       ready_busy_flag_in,
  input  wire logic [7:0] bus_in,
  // strobes and selects
  output logic [1:0]      action_out,
  output logic            load_strobe_out,
  output logic            byte_select_lo_out,
  output logic            byte_select_ext_out,
  output logic            page_latch_strobe_out,
  output logic            write_pulse_n_out,
  output logic            output_enable_n_out,
  // byte driven toward the device
  output logic [7:0]      data_out
);
  int busy_cycles;

  // --------------------------------------------------------------
  // idle levels and programmer actions
  // --------------------------------------------------------------
  initial begin
    action_out = 2'h3;
    load_strobe_out = 1'b0;
    byte_select_lo_out = 1'b0;
    byte_select_ext_out = 1'b0;
    page_latch_strobe_out = 1'b0;
    write_pulse_n_out = 1'b1;
    output_enable_n_out = 1'b1;
    data_out = 8'h00;
    busy_cycles = 0;
  end

  // selects and byte set up one edge ahead, held across the strobe rise
  task automatic load(input logic [1:0] act, input logic bs1, input logic [7:0] val);
    @(posedge ref_clk_in);
    output_enable_n_out <= 1'b1;
    action_out <= act;
    byte_select_lo_out <= bs1;
    data_out <= val;
    @(posedge ref_clk_in);
    load_strobe_out <= 1'b1;
    @(posedge ref_clk_in);
    load_strobe_out <= 1'b0;
    data_out <= ~val;
  endtask

  // positive pulse on the page latch
  task automatic latch(input logic bs1);
    @(posedge ref_clk_in);
    byte_select_lo_out <= bs1;
    page_latch_strobe_out <= 1'b1;
    @(posedge ref_clk_in);
    page_latch_strobe_out <= 1'b0;
  endtask

  // negative write pulse, then count busy cycles until ready again
  task automatic write_page(input logic bs1, input logic bs2);
    @(posedge ref_clk_in);
    byte_select_lo_out <= bs1;
    byte_select_ext_out <= bs2;
    write_pulse_n_out <= 1'b0;
    @(posedge ref_clk_in);
    write_pulse_n_out <= 1'b1;
    busy_cycles = 0;
    #1;
    if (ready_busy_flag_in === 1'b0) busy_cycles++;
    for (int i = 0; i < 200 && !(busy_cycles > 0 && ready_busy_flag_in === 1'b1); i++) begin
      @(posedge ref_clk_in);
      #1;
      if (ready_busy_flag_in === 1'b0) busy_cycles++;
    end
  endtask

  // flip the driven byte, enable output, sample once settled
  task automatic read_byte(input logic bs1, input logic bs2, output logic [7:0] val);
    @(posedge ref_clk_in);
    data_out <= ~data_out;
    byte_select_lo_out <= bs1;
    byte_select_ext_out <= bs2;
    output_enable_n_out <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    #1;
    val = bus_in;
    @(posedge ref_clk_in);
    output_enable_n_out <= 1'b1;
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] alo;
    logic       bs1;
    logic       bs2;
    logic [7:0] exp;
  } row_t;
  localparam int NROWS = 18;
  logic       ref_clk_in;
  logic       resetn_in;
  logic [1:0] act;
  logic       ld, bs1, bs2, lat, wr_n, oe_n, ready, dev_oe_n;
  logic [7:0] prog_data, dev_data, bus, seen, last_cmd;
  int         errors, compares, cycles;
  row_t rows [NROWS] = '{
    '{8'h02, 8'h45, 1'b0, 1'b0, 8'h34}, '{8'h02, 8'h45, 1'b1, 1'b0, 8'h12},
    '{8'h02, 8'h46, 1'b0, 1'b0, 8'hab}, '{8'h02, 8'h46, 1'b1, 1'b0, 8'hcd},
    '{8'h02, 8'h05, 1'b0, 1'b0, 8'hff}, '{8'h03, 8'h09, 1'b0, 1'b0, 8'h77},
    '{8'h03, 8'h09, 1'b1, 1'b0, 8'hff}, '{8'h03, 8'h08, 1'b0, 1'b0, 8'hff},
    '{8'h04, 8'h00, 1'b0, 1'b0, 8'he2}, '{8'h04, 8'h00, 1'b1, 1'b1, 8'hd9},
    '{8'h04, 8'h00, 1'b0, 1'b1, 8'hfd}, '{8'h04, 8'h00, 1'b1, 1'b0, 8'hfc},
    '{8'h08, 8'h00, 1'b0, 1'b0, pp_pkg::SIG_BYTE0}, '{8'h08, 8'h01, 1'b0, 1'b0, pp_pkg::SIG_BYTE1},
    '{8'h08, 8'h02, 1'b0, 1'b0, pp_pkg::SIG_BYTE2}, '{8'h08, 8'h00, 1'b1, 1'b0, pp_pkg::CAL_BYTE},
    '{8'h08, 8'h03, 1'b0, 1'b0, 8'hff}, '{8'h08, 8'h01, 1'b1, 1'b0, 8'hff}};

  // wire level of the shared data bus
  assign bus = (dev_oe_n === 1'b0) ? dev_data : prog_data;

  parallel_program_port #(.FLASH_WRITE_CYCLES(17'h0000a),
    .EE_WRITE_CYCLES(17'h00008), .FUSE_WRITE_CYCLES(17'h00006)) u_parallel_program_port (
    .ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .load_action_hi_in(act[1]),
    .load_action_lo_in(act[0]), .load_strobe_in(ld), .byte_select_lo_in(bs1),
    .byte_select_ext_in(bs2), .page_latch_strobe_in(lat), .write_pulse_n_in(wr_n),
    .output_enable_n_in(oe_n), .data_in(bus), .data_out(dev_data),
    .data_oe_n_out(dev_oe_n), .ready_busy_flag_out(ready));

  programmer_model u_programmer_model (
    .ref_clk_in(ref_clk_in), .ready_busy_flag_in(ready), .bus_in(bus), .action_out(act),
    .load_strobe_out(ld), .byte_select_lo_out(bs1), .byte_select_ext_out(bs2),
    .page_latch_strobe_out(lat), .write_pulse_n_out(wr_n), .output_enable_n_out(oe_n),
    .data_out(prog_data));

  // --------------------------------------------------------------
  // clock, timeout and helpers
  // --------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // cut a hang short
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      results();
    end
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic results();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] v);
    u_programmer_model.load(pp_pkg::ACT_CMD, 1'b0, v);
  endtask
  task automatic adr(input logic b, input logic [7:0] v);
    u_programmer_model.load(pp_pkg::ACT_ADDR, b, v);
  endtask
  task automatic dat(input logic b, input logic [7:0] v);
    u_programmer_model.load(pp_pkg::ACT_DATA, b, v);
  endtask
  task automatic wrc(input logic b1, input logic b2, input int e);
    u_programmer_model.write_page(b1, b2);
    check("busy cycles", 32'(u_programmer_model.busy_cycles), 32'(e));
  endtask

  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    resetn_in = 1'b0;
    errors = 0;
    compares = 0;
    cycles = 0;
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    #1;
    check("ready", 32'(ready), 32'h1);
    check("bus enable", 32'(dev_oe_n), 32'h1);
    // two flash words into page one, then program
    cmd(pp_pkg::CMD_FLASH_WR);
    adr(1'b0, 8'h45);
    dat(1'b0, 8'h34);
    dat(1'b1, 8'h12);
    u_programmer_model.latch(1'b1);
    adr(1'b0, 8'h46);
    dat(1'b0, 8'hab);
    dat(1'b1, 8'hcd);
    u_programmer_model.latch(1'b1);
    adr(1'b1, 8'h00);
    wrc(1'b0, 1'b0, 10);
    cmd(pp_pkg::CMD_NOP);
    // eeprom page: high byte select refused, then programmed
    cmd(pp_pkg::CMD_EE_WR);
    adr(1'b0, 8'h09);
    dat(1'b0, 8'h77);
    u_programmer_model.latch(1'b0);
    wrc(1'b1, 1'b0, 0);
    wrc(1'b0, 1'b0, 8);
    // low, high and extended fuses
    cmd(pp_pkg::CMD_FUSE_WRITE);
    dat(1'b0, 8'he2);
    wrc(1'b0, 1'b0, 6);
    dat(1'b0, 8'hd9);
    wrc(1'b1, 1'b0, 6);
    dat(1'b0, 8'hfd);
    wrc(1'b0, 1'b1, 6);
    // lock mode 3, then boot bits and erase attempts must not land
    cmd(pp_pkg::CMD_LOCK_WRITE);
    dat(1'b0, 8'hfc);
    wrc(1'b0, 1'b0, 6);
    dat(1'b0, 8'hc3);
    wrc(1'b0, 1'b0, 6);
    dat(1'b0, 8'hff);
    wrc(1'b0, 1'b0, 6);
    last_cmd = pp_pkg::CMD_LOCK_WRITE;
    // read back table; command reloaded only when it changes
    for (int r = 0; r < NROWS; r++) begin
      if (rows[r].cmd !== last_cmd) cmd(rows[r].cmd);
      last_cmd = rows[r].cmd;
      adr(1'b0, rows[r].alo);
      u_programmer_model.read_byte(rows[r].bs1, rows[r].bs2, seen);
      check("read byte", 32'(seen), 32'(rows[r].exp));
    end
    // command load with byte select high is ignored
    u_programmer_model.load(pp_pkg::ACT_CMD, 1'b1, pp_pkg::CMD_FLASH_RD);
    adr(1'b0, 8'h00);
    u_programmer_model.read_byte(1'b0, 1'b0, seen);
    check("ignored command", 32'(seen), 32'(pp_pkg::SIG_BYTE0));
    // reset in mid-run restores erased fuses
    @(posedge ref_clk_in);
    resetn_in <= 1'b0;
    repeat (3) @(posedge ref_clk_in);
    resetn_in <= 1'b1;
    cmd(pp_pkg::CMD_FUSE_READ);
    u_programmer_model.read_byte(1'b0, 1'b0, seen);
    check("fuse after reset", 32'(seen), 32'(pp_pkg::FUSE_LO_RST));
    @(posedge ref_clk_in);
    #1;
    check("bus enable idle", 32'(dev_oe_n), 32'h1);
    results();
  end
endmodule
